// ---- blpwm_pkg.sv ----
// Shared constants, types and register map for the backlight mode and PWM control block.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone register bus.
package blpwm_pkg;

    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned OSC_WAIT_US   = 2000;
    localparam int unsigned SOFT_START_US = 4000;
    localparam int unsigned OSC_WAIT_CYC  = (OSC_WAIT_US * (CLK_HZ / 1000000));
    localparam int unsigned SOFT_START_CYC = (SOFT_START_US * (CLK_HZ / 1000000));
    localparam logic [20:0] PWM_IDLE_CYC   = 21'(50000 * (CLK_HZ / 1000000));
    localparam int unsigned POR_SETTLE_CYC = 4;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_BRIGHT = 8'h04;
    localparam logic [7:0] ADDR_CFG    = 8'h08;
    localparam logic [7:0] ADDR_PLL    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_DUTY   = 8'h14;

    // Control register fields.
    localparam int unsigned CTRL_BL_ON    = 0;
    localparam int unsigned CTRL_BOOST_EN = 1;
    localparam int unsigned CTRL_SRC_LO   = 2;
    localparam int unsigned CTRL_SYNC_EN  = 4;
    localparam int unsigned CTRL_FLT_CLR  = 5;
    // Configuration register fields.
    localparam int unsigned CFG_RES_LO    = 0;
    localparam int unsigned CFG_TLIM_LO   = 8;

    localparam logic [31:0] CTRL_RESET   = 32'h0000_0002;
    localparam logic [7:0]  BRIGHT_RESET = 8'hFF;
    localparam logic [11:0] TLIM_RESET   = 12'hC00;
    localparam logic [12:0] PLL_RESET    = 13'h0000;
    localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;

    localparam int unsigned DUTY_W  = 13;
    localparam int unsigned TEMP_W  = 12;
    localparam int unsigned NUM_LED = 6;
    localparam logic [15:0] PWM_CNT_ONE = 16'h0001;

    typedef enum logic [1:0] {
        SRC_DUTY0  = 2'h0,
        SRC_DUTY1  = 2'h1,
        SRC_REG    = 2'h2,
        SRC_DIRECT = 2'h3
    } blpwm_src_t;

    typedef enum logic [4:0] {
        ST_RESET   = 5'h01,
        ST_STANDBY = 5'h02,
        ST_STARTUP = 5'h04,
        ST_SOFT    = 5'h08,
        ST_NORMAL  = 5'h10
    } blpwm_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } blpwm_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } blpwm_wb_rsp_t;

    typedef struct packed {
        logic                thermal_shutdown;
        logic                tempHot;
        logic [TEMP_W-1:0]   temp;
        logic                ledFault;
        logic                overCurrent;
    } blpwm_sense_t;

endpackage : blpwm_pkg

// ---- blpwm_core.sv ----
// Backlight mode sequencer, brightness source selection, PWM clock choice and fault report.
// Assumes a 25 MHz clock, a Wishbone master on the bus and analog sensors delivering levels.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Summary of operation
// - Reset mode restores register defaults; held while supply low.
// - Supply good releases reset into standby.
// - Standby when backlight off, PWM idle, reset released.
// - Writes accepted in standby, effective at once.
// - Backlight bit or PWM high starts startup.
// - Startup waits 2 ms for oscillator.
// - Thermal shutdown holds device in startup.
// - Soft start entered only with boost enabled.
// - Soft start ramps boost for 4 ms.
// - All six LEDs off during soft start.
// - Normal mode takes pin or register control.
// - Faults shown in status register and pin.
// - Derating threshold reduces brightness, except in direct mode.
// - Overtemperature turns boost and LEDs off.
// - Sequencer and measurement run on oscillator tick.
// - PWM clock multiplier set by resolution field.
// - Optional lock of PWM clock to sync.
// - Thirteen-bit count sets PLL output rate.
// - Oscillator clock used until PLL locks.
// - Two-bit field selects brightness source.
// - Duty mode measures 13-bit input duty.
// - Register mode uses 8-bit brightness value.
// - Direct mode follows resampled input PWM.
module blpwm_core
    import blpwm_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                clkEn,
    input  wire logic                supplyGood,
    input  wire logic                enablePin,
    input  wire logic                pwmIn,
    input  wire logic                syncIn,
    input  wire logic                pllLocked,
    input  wire blpwm_sense_t        sense,
    input  wire blpwm_wb_req_t       wbReq,
    output blpwm_wb_rsp_t            wbRsp,
    output logic [NUM_LED-1:0]       ledOn,
    output logic                     boostOn,
    output logic                     boostSoft,
    output logic                     faultOut,
    output logic                     pllSyncSel,
    output logic [1:0]               pllMult,
    output logic [12:0]              pllCount,
    output blpwm_state_t             mode
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers.

    logic       rstMeta_reg;
    logic       rstSync_reg;
    logic [2:0] supSync_reg;
    logic [2:0] enSync_reg;
    logic [2:0] pwmSync_reg;
    logic [2:0] tsdSync_reg;
    logic       supGood_reg;
    logic       enLvl_reg;
    logic       pwmLvl_reg;
    logic       tsdLvl_reg;
    logic       supGood_next;
    logic       enLvl_next;
    logic       pwmLvl_next;
    logic       tsdLvl_next;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end

    // A level changes only once the second and third stages agree.
    function automatic logic agreed(input logic [2:0] s, input logic prev);
        agreed = (s[1] == s[2]) ? s[2] : prev;
    endfunction : agreed

    always_comb begin
        supGood_next = agreed(supSync_reg, supGood_reg);
        enLvl_next   = agreed(enSync_reg, enLvl_reg);
        pwmLvl_next  = agreed(pwmSync_reg, pwmLvl_reg);
        tsdLvl_next  = agreed(tsdSync_reg, tsdLvl_reg);
    end

    always_ff @(posedge clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            supSync_reg <= 3'h0;
            enSync_reg  <= 3'h0;
            pwmSync_reg <= 3'h0;
            tsdSync_reg <= 3'h0;
            supGood_reg <= 1'b0;
            enLvl_reg   <= 1'b0;
            pwmLvl_reg  <= 1'b0;
            tsdLvl_reg  <= 1'b0;
        end else if (clkEn) begin
            supSync_reg <= {supSync_reg[1:0], supplyGood};
            enSync_reg  <= {enSync_reg[1:0], enablePin};
            pwmSync_reg <= {pwmSync_reg[1:0], pwmIn};
            tsdSync_reg <= {tsdSync_reg[1:0], sense.thermal_shutdown};
            supGood_reg <= supGood_next;
            enLvl_reg   <= enLvl_next;
            pwmLvl_reg  <= pwmLvl_next;
            tsdLvl_reg  <= tsdLvl_next;
        end
    end

    // The enable pin powers the regulator, so it counts as supply too.
    logic powerOk;
    assign powerOk = supGood_reg & enLvl_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    logic [31:0]       ctrl_reg;
    logic [7:0]        bright_reg;
    logic [11:0]       tlim_reg;
    logic [1:0]        res_reg;
    logic [12:0]       pll_reg;
    logic              ledFlt_reg;
    logic              ocFlt_reg;
    logic              tsdFlt_reg;
    logic              ack_reg;
    logic [31:0]       rdat_reg;
    logic [31:0]       ctrl_next;
    logic [7:0]        bright_next;
    logic [11:0]       tlim_next;
    logic [1:0]        res_next;
    logic [12:0]       pll_next;
    logic              ledFlt_next;
    logic              ocFlt_next;
    logic              tsdFlt_next;
    logic              ack_next;
    logic [31:0]       rdat_next;
    logic [DUTY_W-1:0] duty_reg;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction : merge

    logic        wbHit;
    logic        wbWr;
    logic        fltClr;
    logic [31:0] cfgWord;
    logic [31:0] wrCtrl;
    logic [31:0] wrBright;
    logic [31:0] wrCfg;
    logic [31:0] wrPll;
    assign wbHit   = wbReq.cyc & wbReq.stb & ~ack_reg;
    assign wbWr    = wbHit & wbReq.we;
    assign cfgWord  = {12'h0, tlim_reg, 6'h00, res_reg};
    assign wrCtrl   = merge(ctrl_reg, wbReq.dat, wbReq.sel);
    assign wrBright = merge({24'h0, bright_reg}, wbReq.dat, wbReq.sel);
    assign wrCfg    = merge(cfgWord, wbReq.dat, wbReq.sel);
    assign wrPll    = merge({19'h0, pll_reg}, wbReq.dat, wbReq.sel);
    assign fltClr   = wbWr && (wbReq.adr == ADDR_CTRL) && wrCtrl[CTRL_FLT_CLR];

    always_comb begin
        ctrl_next   = ctrl_reg;
        bright_next = bright_reg;
        tlim_next   = tlim_reg;
        res_next    = res_reg;
        pll_next    = pll_reg;
        ack_next    = wbHit;
        rdat_next   = rdat_reg;
        // Writes land in every mode except reset, standby included, and act as soon as the
        // sequencer reaches the state that reads them.
        if (wbWr) begin
            unique case (wbReq.adr)
                ADDR_CTRL:   ctrl_next   = {wrCtrl[31:CTRL_FLT_CLR+1], 1'b0, wrCtrl[CTRL_FLT_CLR-1:0]};
                ADDR_BRIGHT: bright_next = wrBright[7:0];
                ADDR_CFG: begin
                    res_next  = wrCfg[CFG_RES_LO +: 2];
                    tlim_next = wrCfg[CFG_TLIM_LO +: TEMP_W];
                end
                ADDR_PLL:    pll_next    = wrPll[12:0];
                default:     ctrl_next   = ctrl_reg;
            endcase
        end
        if (wbHit && !wbReq.we) begin
            unique case (wbReq.adr)
                ADDR_CTRL:   rdat_next = ctrl_reg;
                ADDR_BRIGHT: rdat_next = {24'h0, bright_reg};
                ADDR_CFG:    rdat_next = cfgWord;
                ADDR_PLL:    rdat_next = {19'h0, pll_reg};
                ADDR_STATUS: rdat_next = {22'h0, pllLocked, tsdLvl_reg, mode, tsdFlt_reg, ocFlt_reg, ledFlt_reg};
                ADDR_DUTY:   rdat_next = {19'h0, duty_reg};
                default:     rdat_next = BUS_ERR_DATA;
            endcase
        end
        // Sticky fault flags: a new event wins over a simultaneous clear.
        ledFlt_next = sense.ledFault | (ledFlt_reg & ~fltClr);
        ocFlt_next  = sense.overCurrent | (ocFlt_reg & ~fltClr);
        tsdFlt_next = tsdLvl_reg | (tsdFlt_reg & ~fltClr);
    end

    // Registers return to defaults whenever the sequencer sits in reset.
    logic inResetMode;

    always_ff @(posedge clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            ctrl_reg   <= CTRL_RESET;
            bright_reg <= BRIGHT_RESET;
            tlim_reg   <= TLIM_RESET;
            res_reg    <= 2'h0;
            pll_reg    <= PLL_RESET;
            ledFlt_reg <= 1'b0;
            ocFlt_reg  <= 1'b0;
            tsdFlt_reg <= 1'b0;
            ack_reg    <= 1'b0;
            rdat_reg   <= 32'h0000_0000;
        end else if (clkEn) begin
            ack_reg  <= ack_next;
            rdat_reg <= rdat_next;
            if (inResetMode) begin
                ctrl_reg   <= CTRL_RESET;
                bright_reg <= BRIGHT_RESET;
                tlim_reg   <= TLIM_RESET;
                res_reg    <= 2'h0;
                pll_reg    <= PLL_RESET;
                ledFlt_reg <= 1'b0;
                ocFlt_reg  <= 1'b0;
                tsdFlt_reg <= 1'b0;
            end else begin
                ctrl_reg   <= ctrl_next;
                bright_reg <= bright_next;
                tlim_reg   <= tlim_next;
                res_reg    <= res_next;
                pll_reg    <= pll_next;
                ledFlt_reg <= ledFlt_next;
                ocFlt_reg  <= ocFlt_next;
                tsdFlt_reg <= tsdFlt_next;
            end
        end
    end

    assign wbRsp.ack = ack_reg;
    assign wbRsp.dat = rdat_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencer.

    blpwm_state_t state_reg;
    blpwm_state_t state_next;
    logic [31:0]  timer_reg;
    logic [31:0]  timer_next;
    logic [20:0]  idle_reg;
    logic [20:0]  idle_next;
    logic         wantOn;

    assign inResetMode = (state_reg == ST_RESET);
    assign wantOn      = ctrl_reg[CTRL_BL_ON] | (idle_reg != PWM_IDLE_CYC);

    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        idle_next  = pwmLvl_reg ? 21'h0 : idle_reg + 21'(idle_reg != PWM_IDLE_CYC);
        unique case (state_reg)
            ST_RESET: begin
                timer_next = '0;
                if (powerOk) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                timer_next = '0;
                if (wantOn) begin
                    state_next = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                // Thermal shutdown restarts the wait, so recovery gets the full 2 ms.
                if (tsdLvl_reg) begin
                    timer_next = '0;
                end else if (timer_reg < OSC_WAIT_CYC - 1) begin
                    timer_next = timer_reg + 32'h1;
                end else if (!wantOn) begin
                    state_next = ST_STANDBY;
                    timer_next = '0;
                end else if (ctrl_reg[CTRL_BOOST_EN]) begin
                    state_next = ST_SOFT;
                    timer_next = '0;
                end
            end
            ST_SOFT: begin
                if (tsdLvl_reg) begin
                    state_next = ST_STARTUP;
                    timer_next = '0;
                end else if (timer_reg < SOFT_START_CYC - 1) begin
                    timer_next = timer_reg + 32'h1;
                end else begin
                    state_next = ST_NORMAL;
                    timer_next = '0;
                end
            end
            ST_NORMAL: begin
                timer_next = '0;
                if (tsdLvl_reg) begin
                    state_next = ST_STARTUP;
                end else if (!wantOn) begin
                    state_next = ST_STANDBY;
                end
            end
        endcase
        if (!powerOk) begin
            state_next = ST_RESET;
            timer_next = '0;
            idle_next  = PWM_IDLE_CYC;
        end
    end

    always_ff @(posedge clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            state_reg <= ST_RESET;
            timer_reg <= 32'h0;
            idle_reg  <= PWM_IDLE_CYC;
        end else if (clkEn) begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            idle_reg  <= idle_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Duty measurement, source selection, derating and PWM output.

    logic [DUTY_W-1:0] hiCnt_reg;
    logic [DUTY_W-1:0] perCnt_reg;
    logic [DUTY_W-1:0] hiCnt_next;
    logic [DUTY_W-1:0] perCnt_next;
    logic [DUTY_W-1:0] duty_next;
    logic              pwmPrev_reg;
    logic [DUTY_W-1:0] pwmCnt_reg;
    logic [DUTY_W-1:0] pwmCnt_next;
    logic              pwmOut_reg;
    logic              pwmOut_next;
    logic [DUTY_W-1:0] target;
    logic [DUTY_W-1:0] derated;
    blpwm_src_t        src;

    assign src = blpwm_src_t'(ctrl_reg[CTRL_SRC_LO +: 2]);

    always_comb begin
        // Duty over one input period, scaled to 13 bits with a saturating count.
        hiCnt_next  = hiCnt_reg;
        perCnt_next = perCnt_reg;
        duty_next   = duty_reg;
        if (pwmLvl_reg && !pwmPrev_reg) begin
            if (perCnt_reg != '0) begin
                duty_next = DUTY_W'(({19'h0, hiCnt_reg} << DUTY_W) / {19'h0, perCnt_reg});
            end
            hiCnt_next  = 13'h1;
            perCnt_next = 13'h1;
        end else begin
            if (perCnt_reg != '1) begin
                perCnt_next = perCnt_reg + 13'h1;
            end
            if (pwmLvl_reg && hiCnt_reg != '1) begin
                hiCnt_next = hiCnt_reg + 13'h1;
            end
        end
        unique case (src)
            SRC_REG: target = {bright_reg, 5'h00};
            default: target = duty_reg;
        endcase
        // Halve output at or above the derating threshold.
        derated = (sense.temp >= tlim_reg) ? (target >> 1) : target;
        pwmCnt_next = pwmCnt_reg + 13'h1;
        if (src == SRC_DIRECT) begin
            pwmOut_next = pwmLvl_reg;
        end else begin
            pwmOut_next = (pwmCnt_reg < derated) || (derated == '1);
        end
    end

    always_ff @(posedge clk or negedge rstSync_reg) begin
        if (!rstSync_reg) begin
            hiCnt_reg   <= '0;
            perCnt_reg  <= '0;
            duty_reg    <= '0;
            pwmPrev_reg <= 1'b0;
            pwmCnt_reg  <= '0;
            pwmOut_reg  <= 1'b0;
        end else if (clkEn) begin
            hiCnt_reg   <= hiCnt_next;
            perCnt_reg  <= perCnt_next;
            duty_reg    <= duty_next;
            pwmPrev_reg <= pwmLvl_reg;
            pwmCnt_reg  <= pwmCnt_next;
            pwmOut_reg  <= pwmOut_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    logic running;
    assign running = (state_reg == ST_NORMAL) && !tsdLvl_reg;

    assign ledOn      = (running && pwmOut_reg) ? '1 : '0;
    assign boostOn    = running || (state_reg == ST_SOFT);
    assign boostSoft  = (state_reg == ST_SOFT);
    assign faultOut   = ledFlt_reg | ocFlt_reg | tsdFlt_reg;
    // The external PLL follows sync only once enabled and locked.
    assign pllSyncSel = ctrl_reg[CTRL_SYNC_EN] & pllLocked & syncIn | ctrl_reg[CTRL_SYNC_EN] & pllLocked;
    assign pllMult    = res_reg;
    assign pllCount   = pll_reg;
    assign mode       = state_reg;

endmodule : blpwm_core

// ---- blpwm_core_props.sv ----
// Concurrent checks on the ports of the backlight mode core.
// Assumes the single clk domain and the active-low rst_n of the core.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module blpwm_core_props
    import blpwm_pkg::*;
(
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic          supplyGood,
    input wire blpwm_sense_t  sense,
    input wire blpwm_wb_req_t wbReq,
    input wire blpwm_wb_rsp_t wbRsp,
    input wire logic [NUM_LED-1:0] ledOn,
    input wire logic          boostOn,
    input wire logic          boostSoft,
    input wire logic          faultOut,
    input wire blpwm_state_t  mode
);
    // The thermal input is synchronised inside, so a few cycles of slack.
    localparam int CNT_LO = OSC_WAIT_CYC - 4;
    localparam int CNT_HI = OSC_WAIT_CYC + 4;
    logic [16:0] waitCnt_reg;
    logic [16:0] waitCnt_next;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    always_comb begin
        waitCnt_next = (mode == ST_STARTUP && !sense.thermal_shutdown) ? waitCnt_reg + 17'h00001 : 17'h00000;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitCnt_reg <= 17'h00000;
        end else begin
            waitCnt_reg <= waitCnt_next;
        end
    end
////////////////////////////////////////////////////////////
    property p_ack_next; wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; wbRsp.ack |=> !wbRsp.ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_soft_dark; mode == ST_SOFT |-> ledOn == '0 && boostSoft; endproperty
    a_soft_dark: assert property (p_soft_dark) else $error("leds lit in soft start");
    property p_reset_dark; mode == ST_RESET |-> ledOn == '0 && !boostOn; endproperty
    a_reset_dark: assert property (p_reset_dark) else $error("output active in reset");
    property p_supply_low; !supplyGood [*6] |-> mode == ST_RESET; endproperty
    a_supply_low: assert property (p_supply_low) else $error("not in reset");
    property p_soft_entry; $rose(mode == ST_SOFT) |-> $past(mode) == ST_STARTUP; endproperty
    a_soft_entry: assert property (p_soft_entry) else $error("bad soft entry");
    property p_osc_wait; $rose(mode == ST_SOFT) |-> waitCnt_reg >= CNT_LO && waitCnt_reg <= CNT_HI; endproperty
    a_osc_wait: assert property (p_osc_wait) else $error("startup wait length");
    property p_tsd_stop; sense.thermal_shutdown [*6] |-> !(mode inside {ST_SOFT, ST_NORMAL}) && !boostOn; endproperty
    a_tsd_stop: assert property (p_tsd_stop) else $error("running while hot");
    property p_fault_pin; $rose(sense.ledFault) |-> ##[1:4] faultOut; endproperty
    a_fault_pin: assert property (p_fault_pin) else $error("fault pin silent");
endmodule : blpwm_core_props

bind blpwm_core blpwm_core_props blpwm_core_props_i (
    .clk(clk), .rst_n(rst_n), .supplyGood(supplyGood), .sense(sense), .wbReq(wbReq),
    .wbRsp(wbRsp), .ledOn(ledOn), .boostOn(boostOn), .boostSoft(boostSoft),
    .faultOut(faultOut), .mode(mode)
);

// ---- blpwm_host_model.sv ----
// Host model that drives the PWM input and a line-rate sync pulse.
// Assumes the bench clock; outputs change only after rising edges.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module blpwm_host_model #(
    parameter int PERIOD      = 200,
    parameter int HIGH        = 80,
    parameter int SYNC_PERIOD = 500
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      pwmOut,
    output logic      syncOut
);
    int pwmCnt_reg;
    int pwmCnt_next;
    int syncCnt_reg;
    int syncCnt_next;

    always_comb begin
        pwmCnt_next  = (!run || pwmCnt_reg == PERIOD - 1) ? 0 : pwmCnt_reg + 1;
        syncCnt_next = (!run || syncCnt_reg == SYNC_PERIOD - 1) ? 0 : syncCnt_reg + 1;
    end
    // Both lines rest low when the host is idle, so no stale level is left.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwmCnt_reg  <= 0;
            syncCnt_reg <= 0;
            pwmOut      <= 1'b0;
            syncOut     <= 1'b0;
        end else begin
            pwmCnt_reg  <= pwmCnt_next;
            syncCnt_reg <= syncCnt_next;
            pwmOut      <= run && (pwmCnt_next < HIGH);
            syncOut     <= run && (syncCnt_next == 1);
        end
    end
endmodule : blpwm_host_model

// ---- blpwm_core_tb_top.sv ----
// Self-checking bench for the backlight mode core.
// Assumes a Wishbone master here and the host model on the PWM pins.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module blpwm_core_tb_top
    import blpwm_pkg::*;
;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                supplyGood;
    logic                enablePin;
    logic                hostRun;
    logic                pwmIn;
    logic                syncIn;
    blpwm_sense_t        sense;
    blpwm_wb_req_t       wbReq;
    blpwm_wb_rsp_t       wbRsp;
    logic [NUM_LED-1:0]  ledOn;
    logic                boostOn;
    logic                boostSoft;
    logic                faultOut;
    logic [1:0]          pllMult;
    logic [12:0]         pllCount;
    blpwm_state_t        mode;
    logic [31:0]         q;
    int                  n_mismatch = 0;
    int                  comparisons = 0;

    always #20 clk = ~clk;

    blpwm_host_model blpwm_host_model_i (.clk(clk), .rst_n(rst_n), .run(hostRun), .pwmOut(pwmIn),
        .syncOut(syncIn));
    blpwm_core blpwm_core_i (.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .supplyGood(supplyGood),
        .enablePin(enablePin), .pwmIn(pwmIn), .syncIn(syncIn), .pllLocked(1'b0), .sense(sense),
        .wbReq(wbReq), .wbRsp(wbRsp), .ledOn(ledOn), .boostOn(boostOn), .boostSoft(boostSoft),
        .faultOut(faultOut), .pllSyncSel(), .pllMult(pllMult), .pllCount(pllCount), .mode(mode));
////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // The bus cycle is held until ack is seen; only the watchdog ends a hang.
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
        do begin
            @(posedge clk);
            n++;
        end while (wbRsp.ack !== 1'b1);
        q = wbRsp.dat;
        wbReq <= '0;
        chk(n, 2);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        wb(1'b1, a, s, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 4'hF, 32'h0);
        chk(q, e);
    endtask : rd

    task automatic wait_mode(input blpwm_state_t m, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (mode !== m && n < lim);
        chk({27'h0, mode}, {27'h0, m});
    endtask : wait_mode

    task finish_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
////////////////////////////////////////////////////////////
    initial begin
        supplyGood = 1'b1;
        enablePin = 1'b1;
        hostRun = 1'b0;
        sense = '0;
        sense.temp = 12'h100;
        wbReq = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wait_mode(ST_STANDBY, 10);
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_BRIGHT, {24'h0, BRIGHT_RESET});
        rd(ADDR_CFG, {12'h0, TLIM_RESET, 8'h00});
        rd(ADDR_PLL, 32'h0);
        rd(ADDR_STATUS, {24'h0, ST_STANDBY, 3'h0});
        rd(8'h18, BUS_ERR_DATA);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CTRL, 4'hF, 32'((s << CTRL_SRC_LO) | 2));
            rd(ADDR_CTRL, 32'((s << CTRL_SRC_LO) | 2));
        end
        wr(ADDR_BRIGHT, 4'h0, 32'h0000_0012);
        rd(ADDR_BRIGHT, 32'h0000_00FF);
        wr(ADDR_BRIGHT, 4'h1, 32'h0000_0012);
        rd(ADDR_BRIGHT, 32'h0000_0012);
        wr(ADDR_PLL, 4'hF, 32'h0000_1FFF);
        chk({19'h0, pllCount}, 32'h0000_1FFF);
        wr(ADDR_CFG, 4'hF, 32'h000C_0003);
        chk({30'h0, pllMult}, 32'h3);
        wr(ADDR_CTRL, 4'hF, CTRL_RESET);
        chk({27'h0, mode}, {27'h0, ST_STANDBY});
        hostRun <= 1'b1;
        wait_mode(ST_STARTUP, 20);
        wait_mode(ST_SOFT, 50100);
        chk({26'h0, ledOn}, 32'h0);
        chk({31'h0, boostSoft}, 32'h1);
        rd(ADDR_STATUS, {24'h0, ST_SOFT, 3'h0});
        rd(ADDR_DUTY, 32'h0000_0CCC);
        @(posedge clk);
        sense.thermal_shutdown <= 1'b1;
        wait_mode(ST_STARTUP, 20);
        repeat (8) @(negedge clk);
        chk({31'h0, boostOn}, 32'h0);
        chk({31'h0, faultOut}, 32'h1);
        rd(ADDR_STATUS, {23'h0, 1'b1, ST_STARTUP, 3'h4});
        sense.thermal_shutdown <= 1'b0;
        repeat (100) @(negedge clk);
        chk({27'h0, mode}, {27'h0, ST_STARTUP});
        wr(ADDR_CTRL, 4'hF, 32'h0000_002A);
        repeat (2) @(negedge clk);
        chk({31'h0, faultOut}, 32'h0);
        @(posedge clk);
        sense.ledFault <= 1'b1;
        @(posedge clk);
        sense.ledFault <= 1'b0;
        repeat (4) @(negedge clk);
        chk({31'h0, faultOut}, 32'h1);
        rd(ADDR_STATUS, {24'h0, ST_STARTUP, 3'h1});
        hostRun <= 1'b0;
        enablePin <= 1'b0;
        supplyGood <= 1'b0;
        repeat (8) @(negedge clk);
        chk({27'h0, mode}, {27'h0, ST_RESET});
        enablePin <= 1'b1;
        supplyGood <= 1'b1;
        wait_mode(ST_STANDBY, 20);
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_PLL, 32'h0);
        finish_test;
    end

    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        finish_test;
    end
endmodule : blpwm_core_tb_top
